// ===== common/fifo_frame_pkg.sv
// Shared constants for the FIFO and bit framing register block.
package fifo_frame_pkg;

  // ************************************************************
  // Sizes of the data path.
  // ************************************************************
  localparam int unsigned BYTE_W     = 8;   // Width of one FIFO entry.
  localparam int unsigned FIFO_DEPTH = 64;  // Entries held by the FIFO.
  localparam int unsigned ADDR_W     = 6;   // Width of the register address.
  localparam int unsigned LEVEL_W    = 7;   // Width of the fill count.
  localparam int unsigned WM_W       = 6;   // Width of the watermark value.

  // Fill count at or above which the receive path is held off.
  localparam logic [LEVEL_W-1:0] RX_STOP_LEVEL = 7'h3f;
  // Fill count of a completely full buffer.
  localparam logic [LEVEL_W-1:0] FULL_LEVEL    = 7'h40;

  // ************************************************************
  // Register offsets.
  // ************************************************************
  localparam logic [ADDR_W-1:0] FIFO_DATA_PORT_OFF   = 6'h09;
  localparam logic [ADDR_W-1:0] FIFO_FILL_LEVEL_OFF  = 6'h0a;
  localparam logic [ADDR_W-1:0] FIFO_WATERMARK_OFF   = 6'h0b;
  localparam logic [ADDR_W-1:0] MISC_CONTROL_OFF     = 6'h0c;
  localparam logic [ADDR_W-1:0] BIT_FRAME_ADJUST_OFF = 6'h0d;
  localparam logic [ADDR_W-1:0] BLOCK_STATUS_OFF     = 6'h30;

  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int unsigned FLUSH_BIT      = 7;  // Flush bit of the level register.
  localparam int unsigned TSTOP_BIT      = 7;  // Timer stop bit of the control register.
  localparam int unsigned TSTART_BIT     = 6;  // Timer start bit of the control register.
  localparam int unsigned SEND_BIT       = 7;  // Send trigger of the framing register.
  localparam int unsigned RX_OFFSET_LSB  = 4;  // Low bit of the receive alignment field.
  localparam int unsigned TX_TAIL_LSB    = 0;  // Low bit of the transmit tail field.
  localparam int unsigned ST_OVFL_BIT    = 2;  // Overflow flag in the status register.
  localparam int unsigned ST_HIGH_BIT    = 1;  // High alert in the status register.
  localparam int unsigned ST_LOW_BIT     = 0;  // Low alert in the status register.

  // ************************************************************
  // Reset values.
  // ************************************************************
  localparam logic [WM_W-1:0]   WATERMARK_RESET = 6'h08;
  localparam logic [BYTE_W-1:0] MISC_RSVD_VALUE = 8'h10;
  localparam logic [2:0]        FIELD3_RESET    = 3'h0;

endpackage

// ===== rtl/byte_fifo.sv
// Parameterised first-in first-out buffer held in flip-flops.
`timescale 1ns/1ps

module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_b,
  input  wire logic                         flush,
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic [WIDTH-1:0]             in_data,
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [WIDTH-1:0]                  out_data,
  output logic [$clog2(DEPTH+1)-1:0]        count
);

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH+1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage cells.
  logic [PTR_W-1:0] wr_ptr_q;       // Next cell to write.
  logic [PTR_W-1:0] rd_ptr_q;       // Oldest cell.
  logic [CNT_W-1:0] count_q;        // Entries held.
  logic             push;           // Entry accepted this cycle.
  logic             pop;            // Entry removed this cycle.

  // Advances a pointer and wraps it at the end of the storage.
  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (count_q != FULL_CNT);
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign count     = count_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is written only on an accepted entry.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and count; a flush empties the buffer at once.
  always_ff @(posedge ref_clk) begin
    if (!rst_b || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= bump(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= bump(rd_ptr_q);
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// ===== rtl/fifo_and_bit_framing_regs.sv
// Host registers around the 64-byte FIFO, timer pulses and bit framing fields.
`timescale 1ns/1ps

module fifo_and_bit_framing_regs
  import fifo_frame_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [BYTE_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [BYTE_W-1:0]        reg_rdata,
  input  wire logic                rx_valid,
  output logic                     rx_ready,
  input  wire logic [BYTE_W-1:0]   rx_byte,
  output logic                     tx_valid,
  input  wire logic                tx_ready,
  output logic [BYTE_W-1:0]        tx_byte,
  input  wire logic                rx_tail_load,
  input  wire logic [2:0]          rx_tail_bits,
  input  wire logic                transceive_active,
  output logic                     send_trigger,
  output logic                     timer_start_pulse,
  output logic                     timer_stop_pulse,
  output logic [2:0]               rx_bit_offset,
  output logic [2:0]               tx_tail_bit_count,
  output logic                     high_alert,
  output logic                     low_alert,
  output logic                     overflow_error
);

  // ************************************************************
  // Register strobes.
  // ************************************************************

  logic wr_data;    // Host write to the data port.
  logic rd_data;    // Host read of the data port.
  logic wr_level;   // Host write to the fill level register.
  logic wr_wm;      // Host write to the watermark register.
  logic wr_misc;    // Host write to the control register.
  logic wr_frame;   // Host write to the framing register.
  logic flush;      // Flush requested in this cycle.

  assign wr_data  = reg_wr && (reg_addr == FIFO_DATA_PORT_OFF);
  assign rd_data  = reg_rd && (reg_addr == FIFO_DATA_PORT_OFF);
  assign wr_level = reg_wr && (reg_addr == FIFO_FILL_LEVEL_OFF);
  assign wr_wm    = reg_wr && (reg_addr == FIFO_WATERMARK_OFF);
  assign wr_misc  = reg_wr && (reg_addr == MISC_CONTROL_OFF);
  assign wr_frame = reg_wr && (reg_addr == BIT_FRAME_ADJUST_OFF);
  assign flush    = wr_level && reg_wdata[FLUSH_BIT];

  // ************************************************************
  // Buffer and its feed.
  // ************************************************************

  logic [LEVEL_W-1:0] fifo_count;   // Bytes inside the storage.
  logic               fifo_in_rdy;  // Storage can accept a byte.
  logic               fifo_out_vld; // Storage holds a byte.
  logic [BYTE_W-1:0]  fifo_head;    // Oldest stored byte.
  logic               push_valid;   // A byte is offered to the storage.
  logic [BYTE_W-1:0]  push_byte;    // Byte offered to the storage.
  logic               pop_req;      // A byte is taken from the storage.
  logic               rx_take;      // Receive path hands over a byte.
  logic               host_room;    // A host byte fits into the buffer.
  logic               host_keep;    // Host byte is kept, not discarded.
  logic               tx_load;      // Transmit stage takes the head byte.
  logic [LEVEL_W-1:0] level_d;      // Fill count after this cycle.

  logic               pend_q;       // Host byte waiting to enter storage.
  logic               pend_d;
  logic [BYTE_W-1:0]  pend_byte_q;  // The waiting host byte.
  logic [LEVEL_W-1:0] level_q;      // Fill count seen by the host.
  logic               rx_ready_q;   // Registered receive ready.
  logic               tx_valid_q;   // Transmit stage holds a byte.
  logic [BYTE_W-1:0]  tx_byte_q;    // Byte in the transmit stage.
  logic               tx_run_q;     // Transmission is draining the buffer.
  logic               ovfl_q;       // Host wrote into a full buffer.
  logic               high_q;       // High alert flag.
  logic               low_q;        // Low alert flag.

  // One storage serves both directions as the serial staging buffer.
  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_store (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .flush     (flush),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_rdy),
    .in_data   (push_byte),
    .out_valid (fifo_out_vld),
    .out_ready (pop_req),
    .out_data  (fifo_head),
    .count     (fifo_count)
  );

  // The receive path only hands over when ready was raised a cycle ago.
  assign rx_take = rx_valid && rx_ready_q;

  // Host bytes beyond 64 are dropped instead of being queued.
  assign host_room = (level_q < FULL_LEVEL) || rd_data;
  assign host_keep = wr_data && (level_q < FULL_LEVEL);

  // A receive byte goes first; a clashing host byte waits one cycle.
  always_comb begin
    push_valid = 1'b0;
    push_byte  = rx_byte;
    if (rx_take) begin
      push_valid = 1'b1;
      push_byte  = rx_byte;
    end else if (pend_q) begin
      push_valid = 1'b1;
      push_byte  = pend_byte_q;
    end else if (host_keep) begin
      push_valid = 1'b1;
      push_byte  = reg_wdata;
    end
  end

  // A host byte parks when it collides with a receive byte or a parked one.
  assign pend_d = !flush && host_keep && (rx_take || pend_q);

  // The transmit stage refills only when the host is not popping.
  assign tx_load = tx_run_q && fifo_out_vld && !rd_data && (!tx_valid_q || tx_ready);
  assign pop_req = (rd_data && fifo_out_vld) || tx_load;

  // Fill count after the pushes and pops of this cycle.
  always_comb begin
    level_d = level_q;
    if (flush) begin
      level_d = '0;
    end else begin
      if (rx_take) begin
        level_d = level_d + 1'b1;
      end
      if (host_keep) begin
        level_d = level_d + 1'b1;
      end
      if (pop_req) begin
        level_d = level_d - 1'b1;
      end
    end
  end

  // Holds the parked host byte.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pend_q      <= 1'b0;
      pend_byte_q <= 8'h00;
    end else begin
      pend_q <= pend_d;
      if (pend_d) begin
        pend_byte_q <= reg_wdata;
      end
    end
  end

  // Fill count; a read from an empty buffer leaves it at zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      level_q <= '0;
    end else begin
      level_q <= level_d;
    end
  end

  // Receive ready drops early enough to leave room for one host byte.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_ready_q <= 1'b0;
    end else begin
      rx_ready_q <= !pend_d && (level_d < RX_STOP_LEVEL) && fifo_in_rdy;
    end
  end

  // ************************************************************
  // Transmit stage.
  // ************************************************************

  // Output stage toward the serial transmitter.
  always_ff @(posedge ref_clk) begin
    if (!rst_b || flush) begin
      tx_valid_q <= 1'b0;
      tx_byte_q  <= 8'h00;
    end else if (tx_load) begin
      tx_valid_q <= 1'b1;
      tx_byte_q  <= fifo_head;
    end else if (tx_ready) begin
      tx_valid_q <= 1'b0;
    end
  end

  // Drain runs from an accepted send trigger until the buffer is empty.
  always_ff @(posedge ref_clk) begin
    if (!rst_b || flush) begin
      tx_run_q <= 1'b0;
    end else if (wr_frame && reg_wdata[SEND_BIT] && transceive_active) begin
      tx_run_q <= 1'b1;
    end else if ((fifo_count == '0) && !pend_q) begin
      tx_run_q <= 1'b0;
    end
  end

  // ************************************************************
  // Flags and alerts.
  // ************************************************************

  // Overflow flag; a new overflow wins over a flush in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ovfl_q <= 1'b0;
    end else if (wr_data && !host_room) begin
      ovfl_q <= 1'b1;
    end else if (flush) begin
      ovfl_q <= 1'b0;
    end
  end

  // Compares a byte count with the watermark.
  function automatic logic within_mark(input logic [LEVEL_W-1:0] n,
                                       input logic [WM_W-1:0]    wm);
    within_mark = (n <= {1'b0, wm});
  endfunction

  logic [WM_W-1:0] wm_q;  // Programmed watermark value.
  logic [WM_W-1:0] wm_d;  // Watermark after this cycle.

  assign wm_d = wr_wm ? reg_wdata[WM_W-1:0] : wm_q;

  // Watermark register.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wm_q <= WATERMARK_RESET;
    end else begin
      wm_q <= wm_d;
    end
  end

  // Alerts track the fill count and watermark of the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      high_q <= 1'b0;
      low_q  <= 1'b1;
    end else begin
      high_q <= within_mark(FULL_LEVEL - level_d, wm_d);
      low_q  <= within_mark(level_d, wm_d);
    end
  end

  // ************************************************************
  // Control and framing fields.
  // ************************************************************

  logic       tstart_q;   // Timer start pulse.
  logic       tstop_q;    // Timer stop pulse.
  logic       send_q;     // Send trigger pulse.
  logic [2:0] rx_tail_q;  // Valid bits of the last received byte.
  logic [2:0] rx_off_q;   // Receive bit alignment.
  logic [2:0] tx_tail_q;  // Bits sent of the final byte.

  // One-cycle pulses from the write-only bits.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tstart_q <= 1'b0;
      tstop_q  <= 1'b0;
      send_q   <= 1'b0;
    end else begin
      tstop_q  <= wr_misc && reg_wdata[TSTOP_BIT];
      tstart_q <= wr_misc && reg_wdata[TSTART_BIT];
      send_q   <= wr_frame && reg_wdata[SEND_BIT] && transceive_active;
    end
  end

  // Last received byte status, loaded by the receiver.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_tail_q <= FIELD3_RESET;
    end else if (rx_tail_load) begin
      rx_tail_q <= rx_tail_bits;
    end
  end

  // Framing fields written by the host.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_off_q  <= FIELD3_RESET;
      tx_tail_q <= FIELD3_RESET;
    end else if (wr_frame) begin
      rx_off_q  <= reg_wdata[RX_OFFSET_LSB +: 3];
      tx_tail_q <= reg_wdata[TX_TAIL_LSB +: 3];
    end
  end

  // ************************************************************
  // Read data.
  // ************************************************************

  logic [BYTE_W-1:0] rdata_q;  // Read data for the cycle after a read.
  logic [BYTE_W-1:0] rdata_d;

  // Selects the read value; write-only bits and unmapped space read zero.
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        FIFO_DATA_PORT_OFF: begin
          rdata_d = fifo_out_vld ? fifo_head : 8'h00;
        end
        FIFO_FILL_LEVEL_OFF: begin
          rdata_d = {1'b0, level_q};
        end
        FIFO_WATERMARK_OFF: begin
          rdata_d = {2'b00, wm_q};
        end
        MISC_CONTROL_OFF: begin
          rdata_d = MISC_RSVD_VALUE | {5'h00, rx_tail_q};
        end
        BIT_FRAME_ADJUST_OFF: begin
          rdata_d = {1'b0, rx_off_q, 1'b0, tx_tail_q};
        end
        BLOCK_STATUS_OFF: begin
          rdata_d[ST_OVFL_BIT] = ovfl_q;
          rdata_d[ST_HIGH_BIT] = high_q;
          rdata_d[ST_LOW_BIT]  = low_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************

  assign reg_rdata         = rdata_q;
  assign rx_ready          = rx_ready_q;
  assign tx_valid          = tx_valid_q;
  assign tx_byte           = tx_byte_q;
  assign send_trigger      = send_q;
  assign timer_start_pulse = tstart_q;
  assign timer_stop_pulse  = tstop_q;
  assign rx_bit_offset     = rx_off_q;
  assign tx_tail_bit_count = tx_tail_q;
  assign high_alert        = high_q;
  assign low_alert         = low_q;
  assign overflow_error    = ovfl_q;

endmodule

// ===== dv/serial_path_model.sv
// Behavioural model of the serial receive source and the transmit sink.
`timescale 1ns/1ps

module serial_path_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       rx_go,
  input  wire logic       stall,
  output logic            rx_valid = 1'b0,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_byte = 8'h00,
  input  wire logic       tx_valid,
  output logic            tx_ready = 1'b0,
  input  wire logic [7:0] tx_byte
);
  logic [7:0] next_q = 8'h40;  // Next byte that the receive side offers.
  logic [7:0] got_q [$];       // Bytes taken from the transmit stage, in order.

  // ************************************************************
  // Receive source.
  // ************************************************************
  // An offered byte is held until taken; an idle line shows a changing value.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_valid <= 1'b0;
      next_q   <= 8'h40;
    end else if (!(rx_valid && !rx_ready)) begin
      rx_valid <= rx_go;
      rx_byte  <= rx_go ? next_q : ~rx_byte;
      next_q   <= rx_go ? next_q + 8'h01 : next_q;
    end
  end

  // ************************************************************
  // Transmit sink.
  // ************************************************************
  // The sink stalls on request and logs every byte it takes.
  always @(posedge ref_clk) begin
    tx_ready <= !stall;
    if (tx_valid && tx_ready) begin
      got_q.push_back(tx_byte);
    end
  end
endmodule

// ===== dv/fifo_frame_asserts.sv
// Concurrent checks on the ports of the FIFO and bit framing register block.
`timescale 1ns/1ps

module fifo_frame_checker
  import fifo_frame_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [BYTE_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [BYTE_W-1:0] reg_rdata,
  input wire logic              rx_valid,
  input wire logic              rx_ready,
  input wire logic [BYTE_W-1:0] rx_byte,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic [BYTE_W-1:0] tx_byte,
  input wire logic              rx_tail_load,
  input wire logic [2:0]        rx_tail_bits,
  input wire logic              transceive_active,
  input wire logic              send_trigger,
  input wire logic              timer_start_pulse,
  input wire logic              timer_stop_pulse,
  input wire logic [2:0]        rx_bit_offset,
  input wire logic [2:0]        tx_tail_bit_count,
  input wire logic              high_alert,
  input wire logic              low_alert,
  input wire logic              overflow_error
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ************************************************************
  // Access sequences.
  // ************************************************************
  sequence s_lvl_wr; reg_wr && reg_addr == FIFO_FILL_LEVEL_OFF; endsequence
  sequence s_frm_wr; reg_wr && reg_addr == BIT_FRAME_ADJUST_OFF; endsequence
  sequence s_ctl_rd; reg_rd && reg_addr == MISC_CONTROL_OFF; endsequence

  // ************************************************************
  // Properties.
  // ************************************************************
  property p_stop;
    timer_stop_pulse == $past(reg_wr && reg_addr == MISC_CONTROL_OFF && reg_wdata[7]);
  endproperty
  property p_start;
    timer_start_pulse == $past(reg_wr && reg_addr == MISC_CONTROL_OFF && reg_wdata[6]);
  endproperty
  property p_send;
    send_trigger == $past(reg_wr && reg_addr == BIT_FRAME_ADJUST_OFF && reg_wdata[7]
                          && transceive_active);
  endproperty
  property p_fields;
    s_frm_wr |=> rx_bit_offset == $past(reg_wdata[6:4])
                 && tx_tail_bit_count == $past(reg_wdata[2:0]);
  endproperty
  property p_flush;
    s_lvl_wr ##0 reg_wdata[FLUSH_BIT] |=> !overflow_error;
  endproperty
  property p_sticky;
    overflow_error && !(reg_wr && reg_addr == FIFO_FILL_LEVEL_OFF) |=> overflow_error;
  endproperty
  property p_ctl_read;
    s_ctl_rd |=> reg_rdata[7:3] == 5'h02;
  endproperty
  property p_lvl_read;
    reg_rd && reg_addr == FIFO_FILL_LEVEL_OFF |=> !reg_rdata[7] && reg_rdata[6:0] <= FULL_LEVEL;
  endproperty
  property p_tail;
    rx_tail_load ##1 s_ctl_rd |=> reg_rdata[2:0] == $past(rx_tail_bits, 2);
  endproperty

  a_stop:     assert property (p_stop) else $error("stop pulse mismatch");
  a_start:    assert property (p_start) else $error("start pulse mismatch");
  a_send:     assert property (p_send) else $error("send trigger mismatch");
  a_fields:   assert property (p_fields) else $error("framing fields mismatch");
  a_flush:    assert property (p_flush) else $error("flush left overflow set");
  a_sticky:   assert property (p_sticky) else $error("overflow dropped");
  a_ctl_read: assert property (p_ctl_read) else $error("control upper bits wrong");
  a_lvl_read: assert property (p_lvl_read) else $error("level read wrong");
  a_tail:     assert property (p_tail) else $error("tail bits wrong");
endmodule

bind fifo_and_bit_framing_regs fifo_frame_checker chk_i (.*);

// ===== dv/tb_top.sv
// Self-checking bench for the FIFO and bit framing register block.
`timescale 1ns/1ps

module tb_top
  import fifo_frame_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [7:0]        reg_rdata;
  logic              rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]        rx_byte, tx_byte;
  logic              rx_tail_load = 1'b0;
  logic [2:0]        rx_tail_bits = 3'h0;
  logic              transceive_active = 1'b0;
  logic              send_trigger, timer_start_pulse, timer_stop_pulse;
  logic [2:0]        rx_bit_offset, tx_tail_bit_count;
  logic              high_alert, low_alert, overflow_error;
  logic              rx_go = 1'b0;
  logic              stall = 1'b0;
  int                errors = 0;
  int                tests_run = 0;
  int                n_stop = 0, n_start = 0, n_send = 0;

  fifo_and_bit_framing_regs dut (.*);
  serial_path_model far (.*);

  always #25 ref_clk = ~ref_clk;

  // Counts the one-cycle pulses at the falling edge, where they are settled.
  always @(negedge ref_clk) begin
    n_stop  += int'(timer_stop_pulse === 1'b1);
    n_start += int'(timer_start_pulse === 1'b1);
    n_send  += int'(send_trigger === 1'b1);
  end

  // ************************************************************
  // Bus and compare tasks.
  // ************************************************************
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rd(input string n, input logic [ADDR_W-1:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(n, e, reg_rdata);
    @(posedge ref_clk);
  endtask

  // ************************************************************
  // Scenarios.
  // ************************************************************
  task automatic t_reset();
    chk_rd("fill", FIFO_FILL_LEVEL_OFF, 8'h00);
    chk_rd("watermark", FIFO_WATERMARK_OFF, 8'h08);
    chk_rd("control", MISC_CONTROL_OFF, 8'h10);
    chk_rd("framing", BIT_FRAME_ADJUST_OFF, 8'h00);
    chk_rd("status", BLOCK_STATUS_OFF, 8'h01);
    chk_rd("unmapped", 6'h3f, 8'h00);
  endtask
  task automatic t_fill();
    wr(FIFO_WATERMARK_OFF, 8'h04);
    for (int i = 1; i <= 64; i++) begin
      wr(FIFO_DATA_PORT_OFF, 8'(i));
      chk("low_alert", {7'h00, i <= 4}, {7'h00, low_alert});
      chk("high_alert", {7'h00, 64 - i <= 4}, {7'h00, high_alert});
    end
    chk_rd("fill", FIFO_FILL_LEVEL_OFF, 8'h40);
    wr(FIFO_DATA_PORT_OFF, 8'hee);
    chk("overflow", 8'h01, {7'h00, overflow_error});
    chk_rd("fill", FIFO_FILL_LEVEL_OFF, 8'h40);
    for (int i = 1; i <= 64; i++) chk_rd("fifo_byte", FIFO_DATA_PORT_OFF, 8'(i));
    chk_rd("empty_read", FIFO_DATA_PORT_OFF, 8'h00);
    chk_rd("fill", FIFO_FILL_LEVEL_OFF, 8'h00);
    wr(FIFO_DATA_PORT_OFF, 8'h11);
    wr(FIFO_FILL_LEVEL_OFF, 8'h80);
    chk("overflow", 8'h00, {7'h00, overflow_error});
    chk_rd("fill", FIFO_FILL_LEVEL_OFF, 8'h00);
    wr(FIFO_WATERMARK_OFF, 8'h08);
  endtask
  task automatic t_ctl();
    wr(MISC_CONTROL_OFF, 8'h80);
    wr(MISC_CONTROL_OFF, 8'h40);
    chk("stops", 8'h01, 8'(n_stop));
    chk("starts", 8'h01, 8'(n_start));
    rx_tail_bits <= 3'h5;
    rx_tail_load <= 1'b1;
    @(posedge ref_clk);
    rx_tail_load <= 1'b0;
    chk_rd("control", MISC_CONTROL_OFF, 8'h15);
  endtask
  task automatic t_frame();
    wr(BIT_FRAME_ADJUST_OFF, 8'hf5);
    chk("sends", 8'h00, 8'(n_send));
    chk("offset", 8'h07, {5'h00, rx_bit_offset});
    chk("tx_tail", 8'h05, {5'h00, tx_tail_bit_count});
    chk_rd("framing", BIT_FRAME_ADJUST_OFF, 8'h75);
    stall <= 1'b1;
    for (int i = 0; i < 3; i++) wr(FIFO_DATA_PORT_OFF, 8'ha1 + 8'(i));
    transceive_active <= 1'b1;
    wr(BIT_FRAME_ADJUST_OFF, 8'h80);
    chk("sends", 8'h01, 8'(n_send));
    repeat (4) @(posedge ref_clk);
    chk("stalled", 8'h00, 8'(far.got_q.size()));
    stall <= 1'b0;
    for (int k = 0; k < 50 && far.got_q.size() < 3; k++) @(posedge ref_clk);
    for (int i = 0; i < 3; i++) chk("tx_byte", 8'ha1 + 8'(i), far.got_q[i]);
    transceive_active <= 1'b0;
    chk_rd("fill", FIFO_FILL_LEVEL_OFF, 8'h00);
  endtask
  task automatic t_rx();
    rx_go <= 1'b1;
    for (int k = 0; k < 200 && rx_ready !== 1'b0; k++) @(posedge ref_clk);
    rx_go <= 1'b0;
    chk("rx_ready", 8'h00, {7'h00, rx_ready});
    chk_rd("rx_byte", FIFO_DATA_PORT_OFF, 8'h40);
    chk_rd("rx_byte", FIFO_DATA_PORT_OFF, 8'h41);
    wr(FIFO_FILL_LEVEL_OFF, 8'h80);
    repeat (3) @(posedge ref_clk);
    wr(FIFO_FILL_LEVEL_OFF, 8'h80);
    chk_rd("fill", FIFO_FILL_LEVEL_OFF, 8'h00);
  endtask

  // ************************************************************
  // Verdict and main sequence.
  // ************************************************************
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hang short well after the expected run length.
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize();
  end

  // Holds reset for eight cycles, then runs every scenario.
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_fill();
    t_ctl();
    t_frame();
    t_rx();
    summarize();
  end
endmodule
